// [logic/pupl_top.v]
`timescale 1ns/1ns
`include "pupl_defines.vh"

// Summary of operation
// - Pull-up only when selected and input
// - Output pins never get a pull-up
// - Port-3 select at FF33, four bits
// - Port-7 select at FF37, three bits
// - Port-8 select at FF38, two bits
// - Port-9 select at FF39, eight bits
// - Select bit one enables, zero disables
// - Select registers take bit and byte writes
// - Output-mode write drives latch onto pin
// - Input-mode write updates latch only
// - Output-mode read returns latch value
// - Input-mode read returns pin level
// - Output-mode arithmetic uses and updates latch
// - Input-mode arithmetic may corrupt the latch
// - Bit operations act on whole port
// - Mode zero drives, mode one inputs
module pupl_top #(
   parameter HAS_PORT8 = 1,
   parameter HAS_PORT9 = 1,
   parameter W3 = 4,
   parameter W7 = 3,
   parameter W8 = 2,
   parameter W9 = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // CPU data-memory access
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire cpu_rmw,
   input wire [1:0] cpu_op,
   output reg [7:0] cpu_rdata_ff,
   // Pin direction bits from the mode registers
   input wire [W3-1:0] port3_pin_direction_bit,
   input wire [W7-1:0] port7_pin_direction_bit,
   input wire [W8-1:0] port8_pin_direction_bit,
   input wire [W9-1:0] port9_pin_direction_bit,
   // Port 3 pads
   input wire [W3-1:0] third_port_pins_in,
   output wire [W3-1:0] third_port_pins_out,
   output wire [W3-1:0] third_port_pins_oe,
   output wire [W3-1:0] third_port_pins_pullup,
   // Port 7 pads
   input wire [W7-1:0] seventh_port_pins_in,
   output wire [W7-1:0] seventh_port_pins_out,
   output wire [W7-1:0] seventh_port_pins_oe,
   output wire [W7-1:0] seventh_port_pins_pullup,
   // Port 8 pads
   input wire [W8-1:0] eighth_port_pins_in,
   output wire [W8-1:0] eighth_port_pins_out,
   output wire [W8-1:0] eighth_port_pins_oe,
   output wire [W8-1:0] eighth_port_pins_pullup,
   // Port 9 pads
   input wire [W9-1:0] ninth_port_pins_in,
   output wire [W9-1:0] ninth_port_pins_out,
   output wire [W9-1:0] ninth_port_pins_oe,
   output wire [W9-1:0] ninth_port_pins_pullup
);

   // ****************************************
   // Address decode
   // ****************************************

   // Select register hits
   wire hit_pu3;
   wire hit_pu7;
   wire hit_pu8;
   wire hit_pu9;
   // Port data register hits
   wire hit_pd3;
   wire hit_pd7;
   wire hit_pd8;
   wire hit_pd9;

   assign hit_pu3 = (cpu_addr == `PUPL_ADDR_PU3);
   assign hit_pu7 = (cpu_addr == `PUPL_ADDR_PU7);
   // only in variants with port 8
   assign hit_pu8 = (HAS_PORT8 != 0) && (cpu_addr == `PUPL_ADDR_PU8);
   // only in variants with port 9
   assign hit_pu9 = (HAS_PORT9 != 0) && (cpu_addr == `PUPL_ADDR_PU9);
   // Port data decode follows the same variant gating
   assign hit_pd3 = (cpu_addr == `PUPL_ADDR_PD3);
   assign hit_pd7 = (cpu_addr == `PUPL_ADDR_PD7);
   assign hit_pd8 = (HAS_PORT8 != 0) && (cpu_addr == `PUPL_ADDR_PD8);
   assign hit_pd9 = (HAS_PORT9 != 0) && (cpu_addr == `PUPL_ADDR_PD9);

   // ****************************************
   // Current register and port views
   // ****************************************

   // Select register read values
   wire [7:0] pu3_rd;
   wire [7:0] pu7_rd;
   wire [7:0] pu8_rd;
   wire [7:0] pu9_rd;
   // Port read views, latch or pin per bit
   wire [7:0] pd3_view;
   wire [7:0] pd7_view;
   wire [7:0] pd8_view;
   wire [7:0] pd9_view;
   // Value at the addressed location
   reg [7:0] addr_view;

   // Selected view, zero for an unmapped address
   always @* begin
      addr_view = 8'h00;
      if (hit_pu3) begin
         addr_view = pu3_rd;
      end else if (hit_pu7) begin
         addr_view = pu7_rd;
      end else if (hit_pu8) begin
         addr_view = pu8_rd;
      end else if (hit_pu9) begin
         addr_view = pu9_rd;
      end else if (hit_pd3) begin
         addr_view = pd3_view;
      end else if (hit_pd7) begin
         addr_view = pd7_view;
      end else if (hit_pd8) begin
         addr_view = pd8_view;
      end else if (hit_pd9) begin
         addr_view = pd9_view;
      end
   end

   // ****************************************
   // Read-modify-write unit
   // ****************************************

   // Operation result on the fetched operand
   reg [7:0] rmw_result;
   // Byte finally written to the target
   wire [7:0] wr_byte;
   // Write strobe covering plain and modify writes
   wire wr_any;

   // Operand is the read view of the whole byte, so a bit
   // operation on an input pin copies the pin level into
   // its latch. That is the corruption software must expect.
   always @* begin
      case (cpu_op)
         `PUPL_OP_AND: begin
            rmw_result = addr_view & cpu_wdata;
         end
         `PUPL_OP_OR: begin
            rmw_result = addr_view | cpu_wdata;
         end
         `PUPL_OP_XOR: begin
            rmw_result = addr_view ^ cpu_wdata;
         end
         `PUPL_OP_ADD: begin
            rmw_result = addr_view + cpu_wdata;
         end
         default: begin
            rmw_result = addr_view;
         end
      endcase
   end

   assign wr_any = cpu_wr | cpu_rmw;
   // Plain write takes priority when both strobes rise
   assign wr_byte = cpu_wr ? cpu_wdata : rmw_result;

   // ****************************************
   // Read data register
   // ****************************************

   // Next read data
   wire [7:0] nxt_rdata;

   // Holds the last read until the next read
   assign nxt_rdata = cpu_rd ? addr_view : cpu_rdata_ff;

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         cpu_rdata_ff <= `PUPL_RST_RDATA;
      end else begin
         cpu_rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // Pull-up select registers
   // ****************************************

   pupl_pullup_reg #(
      .WIDTH(W3),
      .MASK(`PUPL_MASK_PU3)
   ) u_pu3 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pu3),
      .wr_data(wr_byte),
      .rd_data(pu3_rd),
      .dir(port3_pin_direction_bit),
      .pullup_en_ff(third_port_pins_pullup)
   );

   pupl_pullup_reg #(
      .WIDTH(W7),
      .MASK(`PUPL_MASK_PU7)
   ) u_pu7 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pu7),
      .wr_data(wr_byte),
      .rd_data(pu7_rd),
      .dir(port7_pin_direction_bit),
      .pullup_en_ff(seventh_port_pins_pullup)
   );

   pupl_pullup_reg #(
      .WIDTH(W8),
      .MASK(`PUPL_MASK_PU8)
   ) u_pu8 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pu8),
      .wr_data(wr_byte),
      .rd_data(pu8_rd),
      .dir(port8_pin_direction_bit),
      .pullup_en_ff(eighth_port_pins_pullup)
   );

   pupl_pullup_reg #(
      .WIDTH(W9),
      .MASK(`PUPL_MASK_PU9)
   ) u_pu9 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pu9),
      .wr_data(wr_byte),
      .rd_data(pu9_rd),
      .dir(port9_pin_direction_bit),
      .pullup_en_ff(ninth_port_pins_pullup)
   );

   // ****************************************
   // Port output latches and drivers
   // ****************************************

   pupl_port_latch #(
      .WIDTH(W3)
   ) u_pd3 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pd3),
      .wr_data(wr_byte),
      .rd_view(pd3_view),
      .dir(port3_pin_direction_bit),
      .pin_in(third_port_pins_in),
      .pin_out_ff(third_port_pins_out),
      .pin_oe_ff(third_port_pins_oe)
   );

   pupl_port_latch #(
      .WIDTH(W7)
   ) u_pd7 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pd7),
      .wr_data(wr_byte),
      .rd_view(pd7_view),
      .dir(port7_pin_direction_bit),
      .pin_in(seventh_port_pins_in),
      .pin_out_ff(seventh_port_pins_out),
      .pin_oe_ff(seventh_port_pins_oe)
   );

   pupl_port_latch #(
      .WIDTH(W8)
   ) u_pd8 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pd8),
      .wr_data(wr_byte),
      .rd_view(pd8_view),
      .dir(port8_pin_direction_bit),
      .pin_in(eighth_port_pins_in),
      .pin_out_ff(eighth_port_pins_out),
      .pin_oe_ff(eighth_port_pins_oe)
   );

   pupl_port_latch #(
      .WIDTH(W9)
   ) u_pd9 (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr_en(wr_any & hit_pd9),
      .wr_data(wr_byte),
      .rd_view(pd9_view),
      .dir(port9_pin_direction_bit),
      .pin_in(ninth_port_pins_in),
      .pin_out_ff(ninth_port_pins_out),
      .pin_oe_ff(ninth_port_pins_oe)
   );

endmodule // pupl_top

// [logic/pupl_defines.vh]
`ifndef PUPL_DEFINES_VH
`define PUPL_DEFINES_VH

// ****************************************
// Pull-up select register addresses
// ****************************************
`define PUPL_ADDR_PU3 16'hFF33
`define PUPL_ADDR_PU7 16'hFF37
`define PUPL_ADDR_PU8 16'hFF38
`define PUPL_ADDR_PU9 16'hFF39

// ****************************************
// Port data register addresses
// ****************************************
`define PUPL_ADDR_PD3 16'hFF03
`define PUPL_ADDR_PD7 16'hFF07
`define PUPL_ADDR_PD8 16'hFF08
`define PUPL_ADDR_PD9 16'hFF09

// ****************************************
// Writable bit masks of pull-up selects
// ****************************************
`define PUPL_MASK_PU3 8'h0F
`define PUPL_MASK_PU7 8'h07
`define PUPL_MASK_PU8 8'h03
`define PUPL_MASK_PU9 8'hFF

// ****************************************
// Reset values
// ****************************************
`define PUPL_RST_PU 8'h00
`define PUPL_RST_LATCH 8'h00
`define PUPL_RST_RDATA 8'h00

// ****************************************
// Read-modify-write operation codes
// ****************************************
`define PUPL_OP_AND 2'h0
`define PUPL_OP_OR 2'h1
`define PUPL_OP_XOR 2'h2
`define PUPL_OP_ADD 2'h3

`endif

// [logic/pupl_pullup_reg.v]
`timescale 1ns/1ns
`include "pupl_defines.vh"

// One pull-up select register and its per-pin pull-up enables
module pupl_pullup_reg #(
   parameter WIDTH = 8,
   parameter [7:0] MASK = 8'hFF
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Register access
   input wire wr_en,
   input wire [7:0] wr_data,
   output wire [7:0] rd_data,
   // Pin direction, 1 means input
   input wire [WIDTH-1:0] dir,
   // Pull-up enables toward the pads
   output reg [WIDTH-1:0] pullup_en_ff
);

   // Stored select bits, fixed-zero positions never set
   reg [7:0] sel_ff;
   // Next values
   wire [7:0] nxt_sel;
   wire [WIDTH-1:0] nxt_pullup_en;

   assign nxt_sel = wr_en ? (wr_data & MASK) : sel_ff;
   assign rd_data = sel_ff & MASK;
   assign nxt_pullup_en = sel_ff[WIDTH-1:0] & dir;

   // ****************************************
   // Select register and enable flops
   // ****************************************
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         sel_ff <= `PUPL_RST_PU;
         pullup_en_ff <= {WIDTH{1'b0}};
      end else begin
         sel_ff <= nxt_sel;
         pullup_en_ff <= nxt_pullup_en;
      end
   end

endmodule // pupl_pullup_reg

// [logic/pupl_port_latch.v]
`timescale 1ns/1ns
`include "pupl_defines.vh"

// Output latch, pin driver and read view of one port
module pupl_port_latch #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Latch load
   input wire wr_en,
   input wire [7:0] wr_data,
   // Value seen by a read or operand fetch
   output reg [7:0] rd_view,
   // Pin direction, 1 means input
   input wire [WIDTH-1:0] dir,
   // Pad signals
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_out_ff,
   output reg [WIDTH-1:0] pin_oe_ff
);

   // Output latch
   reg [WIDTH-1:0] latch_ff;
   // Two-stage pin synchroniser
   reg [WIDTH-1:0] pin_meta_ff;
   reg [WIDTH-1:0] pin_sync_ff;
   // Loop index
   integer i;

   // ****************************************
   // Latch, driver and synchroniser flops
   // ****************************************
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         latch_ff <= {WIDTH{1'b0}};
         pin_out_ff <= {WIDTH{1'b0}};
         pin_oe_ff <= {WIDTH{1'b0}};
         pin_meta_ff <= {WIDTH{1'b0}};
         pin_sync_ff <= {WIDTH{1'b0}};
      end else begin
         if (wr_en) begin
            latch_ff <= wr_data[WIDTH-1:0];
         end
         pin_out_ff <= wr_en ? wr_data[WIDTH-1:0] : latch_ff;
         pin_oe_ff <= ~dir;
         pin_meta_ff <= pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Read view; latch is never touched by a read
   always @* begin
      rd_view = 8'h00;
      for (i = 0; i < WIDTH; i = i + 1) begin
         rd_view[i] = dir[i] ? pin_sync_ff[i] : latch_ff[i];
      end
   end

endmodule // pupl_port_latch

// [verif/pupl_chk.sv]
`timescale 1ns/1ns
`include "pupl_defines.vh"
// ****
// Port-side checker
// ****
module pupl_chk #(
   parameter W3 = 4,
   parameter W9 = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Bus
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire cpu_rmw,
   input wire [1:0] cpu_op,
   input wire [7:0] cpu_rdata_ff,
   // Pads
   input wire [W3-1:0] port3_pin_direction_bit,
   input wire [W9-1:0] port9_pin_direction_bit,
   input wire [W3-1:0] third_port_pins_out,
   input wire [W3-1:0] third_port_pins_oe,
   input wire [W3-1:0] third_port_pins_pullup,
   input wire [W9-1:0] ninth_port_pins_out,
   input wire [W9-1:0] ninth_port_pins_pullup
);
   // Address hits and low write nibble
   wire pd3 = cpu_addr == `PUPL_ADDR_PD3;
   wire pd9 = cpu_addr == `PUPL_ADDR_PD9;
   wire [3:0] wd3 = cpu_wdata[3:0];
   // Own copy of the operations
   function [3:0] op4(input [1:0] op, input [3:0] a, input [3:0] b);
      case (op)
         2'h0: op4 = a & b;
         2'h1: op4 = a | b;
         2'h2: op4 = a ^ b;
         default: op4 = a + b;
      endcase
   endfunction
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   property p_pu3;
      !(third_port_pins_pullup & ~$past(port3_pin_direction_bit));
   endproperty
   a_pu3: assert property (p_pu3) else $error("pullup on output");
   property p_pu9;
      !(ninth_port_pins_pullup & ~$past(port9_pin_direction_bit));
   endproperty
   a_pu9: assert property (p_pu9) else $error("pullup on output");
   property p_oe3;
      $past(reset_n) |->
         third_port_pins_oe == ~$past(port3_pin_direction_bit);
   endproperty
   a_oe3: assert property (p_oe3) else $error("oe not mode");
   property p_wr3;
      cpu_wr && pd3 |=> third_port_pins_out == $past(wd3);
   endproperty
   a_wr3: assert property (p_wr3) else $error("latch not loaded");
   property p_wr9;
      cpu_wr && pd9 |=> ninth_port_pins_out == $past(cpu_wdata);
   endproperty
   a_wr9: assert property (p_wr9) else $error("latch not loaded");
   property p_hold3;
      !((cpu_wr || cpu_rmw) && pd3) |=> $stable(third_port_pins_out);
   endproperty
   a_hold3: assert property (p_hold3) else $error("latch moved");
   property p_rmw3;
      cpu_rmw && !cpu_wr && pd3 && !port3_pin_direction_bit |=>
         third_port_pins_out == op4($past(cpu_op),
         $past(third_port_pins_out), $past(wd3));
   endproperty
   a_rmw3: assert property (p_rmw3) else $error("bad rmw result");
   property p_rsv;
      cpu_rd && cpu_addr == `PUPL_ADDR_PU3 |=> cpu_rdata_ff[7:4] == 4'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("fixed bits set");
   property p_clr9;
      cpu_wr && cpu_addr == `PUPL_ADDR_PU9 && cpu_wdata == 8'h00 |->
         ##2 ninth_port_pins_pullup == 8'h00;
   endproperty
   a_clr9: assert property (p_clr9) else $error("pullup stuck");
   // Main scenarios seen
   c_rmw9: cover property (cpu_rmw && pd9);
   c_pu9: cover property (|ninth_port_pins_pullup);
   c_rd3: cover property (cpu_rd && pd3);
endmodule // pupl_chk

bind pupl_top pupl_chk #(.W3(W3), .W9(W9)) u_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
   .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
   .cpu_rmw(cpu_rmw), .cpu_op(cpu_op), .cpu_rdata_ff(cpu_rdata_ff),
   .port3_pin_direction_bit(port3_pin_direction_bit),
   .port9_pin_direction_bit(port9_pin_direction_bit),
   .third_port_pins_out(third_port_pins_out),
   .third_port_pins_oe(third_port_pins_oe),
   .third_port_pins_pullup(third_port_pins_pullup),
   .ninth_port_pins_out(ninth_port_pins_out),
   .ninth_port_pins_pullup(ninth_port_pins_pullup));

// [verif/pupl_pin_model.sv]
`timescale 1ns/1ns
// ****
// Far-side pin circuit
// ****
module pupl_pin_model #(
   parameter W = 8
) (
   // Clock
   input wire sys_clk,
   // Device pad side
   input wire [W-1:0] drv_out,
   input wire [W-1:0] drv_oe,
   input wire [W-1:0] pu_en,
   // External source
   input wire [W-1:0] ext_val,
   input wire [W-1:0] ext_en,
   // Resolved level
   output wire [W-1:0] level
);
   // Floating pins wander, so no stale value can pass for a read
   reg [W-1:0] wander_ff = {W{1'b0}};
   always @(posedge sys_clk) begin
      wander_ff <= ~wander_ff;
   end
   assign level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val) |
      (~drv_oe & ~ext_en & (pu_en | wander_ff));
endmodule // pupl_pin_model

// [verif/tb_port_pullup_and_latch_logic.sv]
`timescale 1ns/1ns
`include "pupl_defines.vh"
`define CHK(got, exp) begin \
   checked = checked + 1; \
   if ((got) !== (exp)) begin \
      num_errors = num_errors + 1; \
      $display("Error %0t: got %h exp %h", $time, got, exp); \
   end \
end
module tb_port_pullup_and_latch_logic;
   // ****
   // Drive and observe
   // ****
   reg sys_clk, reset_n, cpu_wr, cpu_rd, cpu_rmw, ext_on;
   reg [15:0] cpu_addr;
   reg [7:0] cpu_wdata, rd, ext, v, x, m, dir9;
   reg [1:0] cpu_op, dir8;
   reg [3:0] dir3;
   reg [2:0] dir7;
   wire [7:0] cpu_rdata_ff, out9, oe9, pu9, lv9;
   wire [3:0] out3, oe3, pu3, lv3;
   wire [2:0] out7, oe7, pu7, lv7;
   wire [1:0] out8, oe8, pu8, lv8;
   integer num_errors, checked, seed, i;
   // Select addresses and writable bits, lowest entry first
   localparam [63:0] PUA = {16'hFF39, 16'hFF38, 16'hFF37, 16'hFF33};
   localparam [31:0] PUM = {8'hFF, 8'h03, 8'h07, 8'h0F};
   pupl_top dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_rmw(cpu_rmw), .cpu_op(cpu_op), .cpu_rdata_ff(cpu_rdata_ff),
      .port3_pin_direction_bit(dir3), .port7_pin_direction_bit(dir7),
      .port8_pin_direction_bit(dir8), .port9_pin_direction_bit(dir9),
      .third_port_pins_in(lv3), .third_port_pins_out(out3),
      .third_port_pins_oe(oe3), .third_port_pins_pullup(pu3),
      .seventh_port_pins_in(lv7), .seventh_port_pins_out(out7),
      .seventh_port_pins_oe(oe7), .seventh_port_pins_pullup(pu7),
      .eighth_port_pins_in(lv8), .eighth_port_pins_out(out8),
      .eighth_port_pins_oe(oe8), .eighth_port_pins_pullup(pu8),
      .ninth_port_pins_in(lv9), .ninth_port_pins_out(out9),
      .ninth_port_pins_oe(oe9), .ninth_port_pins_pullup(pu9));
   // Outside circuits on each port
   pupl_pin_model #(.W(4)) pm3 (.sys_clk(sys_clk), .drv_out(out3),
      .drv_oe(oe3), .pu_en(pu3), .ext_val(ext[3:0]),
      .ext_en(dir3 & {4{ext_on}}), .level(lv3));
   pupl_pin_model #(.W(3)) pm7 (.sys_clk(sys_clk), .drv_out(out7),
      .drv_oe(oe7), .pu_en(pu7), .ext_val(ext[2:0]),
      .ext_en(dir7 & {3{ext_on}}), .level(lv7));
   pupl_pin_model #(.W(2)) pm8 (.sys_clk(sys_clk), .drv_out(out8),
      .drv_oe(oe8), .pu_en(pu8), .ext_val(ext[1:0]),
      .ext_en(dir8 & {2{ext_on}}), .level(lv8));
   pupl_pin_model #(.W(8)) pm9 (.sys_clk(sys_clk), .drv_out(out9),
      .drv_oe(oe9), .pu_en(pu9), .ext_val(ext),
      .ext_en(dir9 & {8{ext_on}}), .level(lv9));
   // Expected operation result
   function [7:0] opf(input [1:0] op, input [7:0] a, input [7:0] b);
      case (op)
         2'h0: opf = a & b;
         2'h1: opf = a | b;
         2'h2: opf = a ^ b;
         default: opf = a + b;
      endcase
   endfunction
   // One access: 0 write, 1 read, 2 read-modify-write
   task bus(input [1:0] k, input [15:0] a, input [7:0] d, input [1:0] op);
      begin
         @(posedge sys_clk);
         cpu_addr <= a;
         cpu_wdata <= d;
         cpu_op <= op;
         cpu_wr <= k == 2'h0;
         cpu_rd <= k == 2'h1;
         cpu_rmw <= k == 2'h2;
         @(posedge sys_clk);
         {cpu_wr, cpu_rd, cpu_rmw} <= 3'h0;
         #1 rd = cpu_rdata_ff;
      end
   endtask
   // Counts, verdict and stop
   task end_sim;
      begin
         $display("Errors %0d, checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
         end else begin
            $display("TB: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Watchdog so a hang still ends the run
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors = num_errors + 1;
      end_sim;
   end
   initial begin
      seed = 32'h7C80;
      num_errors = 0;
      checked = 0;
      {reset_n, cpu_wr, cpu_rd, cpu_rmw, ext_on} = 5'h00;
      {cpu_addr, cpu_wdata, cpu_op, ext} = 34'h0;
      // Port 3 all outputs, ports 7, 8 and 9 all inputs
      {dir3, dir7, dir8, dir9} = 17'h01FFF;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      // Reset value, byte write, bit clear on every select
      for (i = 0; i < 4; i = i + 1) begin
         bus(2'h1, PUA[16*i +: 16], 8'h00, 2'h0);
         `CHK(rd, 8'h00)
         bus(2'h0, PUA[16*i +: 16], 8'hFF, 2'h0);
         bus(2'h1, PUA[16*i +: 16], 8'h00, 2'h0);
         `CHK(rd, PUM[8*i +: 8])
         bus(2'h2, PUA[16*i +: 16], 8'hFE, 2'h0);
         bus(2'h1, PUA[16*i +: 16], 8'h00, 2'h0);
         `CHK(rd, PUM[8*i +: 8] & 8'hFE)
      end
      // selected inputs pulled: FE, 02, 06 on inputs
      `CHK({pu9, pu8, pu7}, 13'h1FD6)
      `CHK(pu3, 4'h0)
      `CHK(lv9[7:1], 7'h7F)
      @(posedge sys_clk);
      dir9 <= 8'h0F;
      repeat (2) @(posedge sys_clk);
      #1 `CHK(pu9, 8'h0E)
      // Unmapped place ignores writes
      bus(2'h0, 16'hFF3A, 8'hFF, 2'h0);
      bus(2'h1, 16'hFF3A, 8'h00, 2'h0);
      `CHK(rd, 8'h00)
      bus(2'h0, 16'hFF39, 8'h00, 2'h0);
      @(posedge sys_clk);
      #1 `CHK(pu9, 8'h00)
      ext_on <= 1'b1;
      // Random mode mix, all four operations in turn
      for (i = 0; i < 40; i = i + 1) begin
         @(posedge sys_clk);
         dir9 <= $random(seed);
         {dir8, dir7} <= $random(seed);
         ext <= $random(seed);
         v = $random(seed);
         x = $random(seed);
         bus(2'h0, `PUPL_ADDR_PD9, v, 2'h0);
         `CHK(out9, v)
         `CHK(oe9, ~dir9)
         // Ports 7 and 8 drive and enable too
         bus(2'h0, `PUPL_ADDR_PD7, v, 2'h0);
         `CHK(out7, v[2:0])
         `CHK(oe7, ~dir7)
         bus(2'h0, `PUPL_ADDR_PD8, x, 2'h0);
         `CHK(out8, x[1:0])
         `CHK(oe8, ~dir8)
         bus(2'h1, `PUPL_ADDR_PD9, 8'h00, 2'h0);
         `CHK(rd, (v & ~dir9) | (ext & dir9))
         `CHK(out9, v)
         m = opf(i[1:0], (v & ~dir9) | (ext & dir9), x);
         bus(2'h2, `PUPL_ADDR_PD9, x, i[1:0]);
         `CHK(out9 & ~dir9, m & ~dir9)
         `CHK(lv9 & dir9, ext & dir9)
         bus(2'h0, `PUPL_ADDR_PD3, v, 2'h0);
         bus(2'h2, `PUPL_ADDR_PD3, x, i[1:0]);
         bus(2'h1, `PUPL_ADDR_PD3, 8'h00, 2'h0);
         m = opf(i[1:0], v, x);
         `CHK(rd[3:0], m[3:0])
      end
      end_sim;
   end
endmodule // tb_port_pullup_and_latch_logic
